// ---- src/sbcwd_bus_if.sv ----
`timescale 1ns/1ns
// Decoded register access between front end and bank
interface sbcwd_bus_if;
   logic wr_hw;
   logic wr_wd;
   logic [7:0] wdata;
   modport dec (output wr_hw, output wr_wd, output wdata);
   modport bank (input wr_hw, input wr_wd, input wdata);
endinterface : sbcwd_bus_if

// ---- src/sbcwd_decode.sv ----
`timescale 1ns/1ns
// Turns one register command into write strobes
module sbcwd_decode (
   input wire logic cmd_valid_i,
   input wire logic [7:0] cmd_i,
   input wire logic [7:0] cmd_wdata_i,
   sbcwd_bus_if.dec bus
);
   logic is_write;
   // Bit seven of the command marks a write
   assign is_write = cmd_valid_i && cmd_i[sbcwd_pkg::SPI_WRITE_BIT];
   assign bus.wr_hw = is_write && (cmd_i[6:0] == sbcwd_pkg::ADDR_HW_CTRL0);
   assign bus.wr_wd = is_write && (cmd_i[6:0] == sbcwd_pkg::ADDR_WATCHDOG_CONTROL);
   assign bus.wdata = cmd_wdata_i;
endmodule : sbcwd_decode

// ---- src/sbcwd_pkg.sv ----
// Function
// - Select bit decides reset pull on soft reset
// - Force bit drives fail output if configured
// - Failure holds fail output until flag cleared
// - Restart clears force bit, releases fail output
// - Charge pump enable bit switches pump output
// - Count select picks first or second failure
// - Locks keep protected bits across soft reset
// - Restart keeps select, pump, count bits only
// - Reserved bits always read zero
// - Stop disable bit, hardware may modify it
// - Type bit picks time-out or window watchdog
// - Bus wake start bit starts long window
// - Watchdog byte power-on and restart values
// - Locked bits ignore writes
package sbcwd_pkg;
   localparam logic [6:0] ADDR_HW_CTRL0 = 7'h02;
   localparam logic [6:0] ADDR_WATCHDOG_CONTROL = 7'h03;
   localparam int HW_RST_SEL_BIT = 6;
   localparam int HW_FO_FORCE_BIT = 5;
   localparam int HW_CHARGE_PUMP_ENABLE_BIT = 2;
   localparam int HW_FAIL_CNT_BIT = 0;
   localparam logic [7:0] HW_WRITE_MASK = 8'h65;
   localparam logic [7:0] HW_RESTART_KEEP = 8'h45;
   localparam logic [7:0] HW_POR_VALUE = 8'h00;
   localparam int WD_PARITY_BIT = 7;
   localparam int WD_STOP_DIS_BIT = 6;
   localparam int WD_WINDOW_BIT = 5;
   localparam int WD_BUS_WAKE_BIT = 4;
   localparam logic [7:0] WD_WRITE_MASK = 8'hf7;
   localparam logic [7:0] WD_POR_VALUE = 8'h14;
   localparam logic [7:0] WD_RESTART_KEEP = 8'hb0;
   localparam logic [7:0] WD_RESTART_LOW = 8'h04;
   localparam int SPI_WRITE_BIT = 7;
endpackage : sbcwd_pkg

// ---- src/sbcwd_regs.sv ----
`timescale 1ns/1ns
// Hardware control and watchdog control bytes of the register bank
module sbcwd_regs (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic cmd_valid_i,
   input wire logic [7:0] cmd_i,
   input wire logic [7:0] cmd_wdata_i,
   input wire logic soft_reset_i,
   input wire logic restart_entry_i,
   input wire logic cfg_lock0_i,
   input wire logic cfg_lock1_i,
   input wire logic fo_configured_i,
   input wire logic failure_flag_i,
   input wire logic hw_stop_dis_set_i,
   input wire logic hw_stop_dis_clr_i,
   input wire logic hw_period_wr_i,
   input wire logic [2:0] hw_period_i,
   output logic [7:0] rdata_o,
   output logic rst_out_low_o,
   output logic fail_output_o,
   output logic charge_pump_enable_o,
   output logic wd_fail_count_select_o,
   output logic wd_stop_disable_lo_o,
   output logic wd_window_select_o,
   output logic wd_start_on_bus_wake_o,
   output logic [2:0] wd_period_select_o
);
   logic [7:0] hw_q;
   logic [7:0] hw_d;
   logic [7:0] wd_q;
   logic [7:0] wd_d;
   logic [7:0] rdata_q;
   logic [7:0] rdata_d;
   logic fo_q;
   logic fo_d;
   logic rstl_q;
   logic rstl_d;
   logic [7:0] hw_lockm;
   logic [7:0] hw_wmask;
   sbcwd_bus_if bus ();

   sbcwd_decode u_dec (
      .cmd_valid_i(cmd_valid_i),
      .cmd_i(cmd_i),
      .cmd_wdata_i(cmd_wdata_i),
      .bus(bus)
   );

   // Mask of bits currently frozen by a lock
   always_comb begin
      hw_lockm = 8'h00;
      hw_lockm[sbcwd_pkg::HW_RST_SEL_BIT] = cfg_lock1_i;
      hw_lockm[sbcwd_pkg::HW_CHARGE_PUMP_ENABLE_BIT] = cfg_lock0_i;
      hw_wmask = sbcwd_pkg::HW_WRITE_MASK & ~hw_lockm;
   end

   // Hardware control next value; restart outranks soft reset and writes
   always_comb begin
      hw_d = hw_q;
      if (restart_entry_i) begin
         hw_d = hw_q & sbcwd_pkg::HW_RESTART_KEEP;
      end else if (soft_reset_i) begin
         hw_d = (hw_q & hw_lockm) | (sbcwd_pkg::HW_POR_VALUE & ~hw_lockm);
      end else if (bus.wr_hw) begin
         hw_d = (hw_q & ~hw_wmask) | (bus.wdata & hw_wmask);
      end
   end

   // Watchdog control next value; hardware updates win over a write
   always_comb begin
      wd_d = wd_q;
      if (soft_reset_i) begin
         wd_d = sbcwd_pkg::WD_POR_VALUE;
      end else if (restart_entry_i) begin
         wd_d = (wd_q & sbcwd_pkg::WD_RESTART_KEEP) | sbcwd_pkg::WD_RESTART_LOW;
      end else begin
         if (bus.wr_wd) begin
            // Parity is software's job, stored as written
            wd_d = bus.wdata & sbcwd_pkg::WD_WRITE_MASK;
         end
         if (hw_stop_dis_set_i) begin
            wd_d[sbcwd_pkg::WD_STOP_DIS_BIT] = 1'b1;
         end else if (hw_stop_dis_clr_i) begin
            wd_d[sbcwd_pkg::WD_STOP_DIS_BIT] = 1'b0;
         end
         if (hw_period_wr_i) begin
            wd_d[2:0] = hw_period_i;
         end
      end
   end

   // Fail output: software force or latched failure, held while flag stands
   always_comb begin
      fo_d = failure_flag_i;
      if (hw_d[sbcwd_pkg::HW_FO_FORCE_BIT] && fo_configured_i) begin
         fo_d = 1'b1;
      end
   end

   // Reset pin pulled low on soft reset unless select bit says otherwise
   always_comb begin
      rstl_d = soft_reset_i && !hw_q[sbcwd_pkg::HW_RST_SEL_BIT];
   end

   // Read data mux; unmapped addresses return zero
   always_comb begin
      rdata_d = 8'h00;
      if (cmd_i[6:0] == sbcwd_pkg::ADDR_HW_CTRL0) begin
         rdata_d = hw_d;
      end else if (cmd_i[6:0] == sbcwd_pkg::ADDR_WATCHDOG_CONTROL) begin
         rdata_d = wd_d;
      end
   end

   // Hardware control byte; power-on value, locks not yet set
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         hw_q <= sbcwd_pkg::HW_POR_VALUE;
      end else begin
         hw_q <= hw_d;
      end
   end

   // Watchdog control byte; power-on value carries valid parity
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         wd_q <= sbcwd_pkg::WD_POR_VALUE;
      end else begin
         wd_q <= wd_d;
      end
   end

   // Fail output flop; registered so the pin never glitches
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         fo_q <= 1'b0;
      end else begin
         fo_q <= fo_d;
      end
   end

   // Reset pull flop; one cycle behind the soft reset pulse
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         rstl_q <= 1'b0;
      end else begin
         rstl_q <= rstl_d;
      end
   end

   // Read data flop; shows the byte as it will stand after this cycle
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         rdata_q <= 8'h00;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   // Outputs straight from the state flops
   assign rdata_o = rdata_q;
   assign rst_out_low_o = rstl_q;
   assign fail_output_o = fo_q;
   assign charge_pump_enable_o = hw_q[sbcwd_pkg::HW_CHARGE_PUMP_ENABLE_BIT];
   assign wd_fail_count_select_o = hw_q[sbcwd_pkg::HW_FAIL_CNT_BIT];
   assign wd_stop_disable_lo_o = wd_q[sbcwd_pkg::WD_STOP_DIS_BIT];
   assign wd_window_select_o = wd_q[sbcwd_pkg::WD_WINDOW_BIT];
   assign wd_start_on_bus_wake_o = wd_q[sbcwd_pkg::WD_BUS_WAKE_BIT];
   assign wd_period_select_o = wd_q[2:0];
endmodule : sbcwd_regs

// ---- testbench/sbcwd_chk.sv ----
`timescale 1ns/1ns
// Port checks on the control bytes
module sbcwd_chk (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic cmd_valid_i,
   input wire logic [7:0] cmd_i,
   input wire logic [7:0] cmd_wdata_i,
   input wire logic soft_reset_i,
   input wire logic restart_entry_i,
   input wire logic cfg_lock0_i,
   input wire logic failure_flag_i,
   input wire logic [7:0] rdata_o,
   input wire logic rst_out_low_o,
   input wire logic fail_output_o,
   input wire logic charge_pump_enable_o,
   input wire logic wd_fail_count_select_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);
   // Read-back, writes, locks, restart
   hw_rsv_a: assert property ($past(cmd_i[6:0])==7'h02 |-> !(rdata_o&8'h9a))
      else $error("hw reserved set");
   wd_rsv_a: assert property ($past(cmd_i[6:0])==7'h03 |-> !rdata_o[3])
      else $error("wd reserved set");
   hw_wr_a: assert property (cmd_valid_i && cmd_i==8'h82 && !cfg_lock0_i
      && !soft_reset_i && !restart_entry_i |=> charge_pump_enable_o==$past(cmd_wdata_i[2])
      && wd_fail_count_select_o==$past(cmd_wdata_i[0])) else $error("hw write lost");
   pump_lock_a: assert property (cfg_lock0_i |=> $stable(charge_pump_enable_o))
      else $error("locked pump moved");
   hw_keep_a: assert property (restart_entry_i |=> $stable(charge_pump_enable_o)
      && $stable(wd_fail_count_select_o)) else $error("restart lost bits");
   // Pins; the reset pull only ever follows a soft reset
   rst_pull_a: assert property (!soft_reset_i |=> !rst_out_low_o)
      else $error("stray reset pull");
   fail_hold_a: assert property (failure_flag_i |=> fail_output_o)
      else $error("fail output dropped");
   fo_rst_a: assert property (restart_entry_i && !failure_flag_i |=> !fail_output_o)
      else $error("fail output kept");
endmodule : sbcwd_chk
bind sbcwd_regs sbcwd_chk chk_u (.*);

// ---- testbench/sbcwd_mcu.sv ----
`timescale 1ns/1ns
// Microcontroller: one command byte per call
module sbcwd_mcu (
   input wire logic clk_i,
   output logic cmd_valid_o = 1'h0,
   output logic [7:0] cmd_o = 8'h00,
   output logic [7:0] cmd_wdata_o = 8'h00
);
   // Released lines inverted so stale bytes never pass
   task xfer(input logic [7:0] c, input logic [7:0] d);
      @(posedge clk_i);
      cmd_valid_o <= 1'h1;
      cmd_o <= c;
      cmd_wdata_o <= c[6:0]==7'h03 ? {^d[6:0], d[6:0]} : d;
      @(posedge clk_i);
      cmd_valid_o <= 1'h0;
      cmd_o <= ~c;
      cmd_wdata_o <= ~d;
   endtask : xfer
endmodule : sbcwd_mcu

// ---- testbench/tb_top.sv ----
`timescale 1ns/1ns
// Driver notes results, monitor compares
module tb_top;
   logic clk_i = 1'h0, sys_rst_i = 1'h1, vld_q = 1'h0, cmd_valid_i;
   logic [7:0] cmd_i, cmd_wdata_i, rdata_o, d, exp_q[$];
   logic [4:0] pul = 5'h00;
   logic [3:0] lvl = 4'h0;
   logic [2:0] hw_period_i, wd_period_select_o;
   logic soft_reset_i, restart_entry_i, hw_stop_dis_set_i, hw_stop_dis_clr_i, hw_period_wr_i;
   logic cfg_lock0_i, cfg_lock1_i, fo_configured_i, failure_flag_i, rst_out_low_o;
   logic fail_output_o, charge_pump_enable_o, wd_fail_count_select_o, wd_stop_disable_lo_o;
   logic wd_window_select_o, wd_start_on_bus_wake_o;
   int seed = 23, miscompares = 0, checks_done = 0;
   // Pulses and levels packed for one-line steps
   assign {soft_reset_i, restart_entry_i, hw_stop_dis_set_i} = pul[4:2];
   assign {hw_stop_dis_clr_i, hw_period_wr_i} = pul[1:0];
   assign {failure_flag_i, fo_configured_i, cfg_lock1_i, cfg_lock0_i} = lvl;
   always #20 clk_i = ~clk_i;
   sbcwd_regs dut_u (.*);
   sbcwd_mcu mcu_u (.clk_i(clk_i), .cmd_valid_o(cmd_valid_i), .cmd_o(cmd_i),
      .cmd_wdata_o(cmd_wdata_i));
   task chk(input string n, input logic [7:0] e, input logic [7:0] g);
      checks_done++;
      if (g !== e) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   // Read-back lands one cycle after the command
   always @(posedge clk_i) vld_q <= cmd_valid_i;
   always @(negedge clk_i) if (vld_q === 1'h1) chk("rdata", exp_q.pop_front(), rdata_o);
   task op(input logic [7:0] c, input logic [7:0] w, input logic [7:0] e);
      exp_q.push_back(e);
      mcu_u.xfer(c, w);
   endtask : op
   task step(input logic [3:0] l, input logic [4:0] p);
      @(posedge clk_i);
      lvl <= l;
      pul <= p;
      @(posedge clk_i);
      pul <= 5'h00;
      @(negedge clk_i);
   endtask : step
   task results;
      $display("checks %0d miscompares %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : results
   // Hang guard
   initial begin
      repeat (3000) @(posedge clk_i);
      miscompares++;
      results();
   end
   initial begin
      hw_period_i = 3'($random(seed));
      repeat (12) @(posedge clk_i);
      sys_rst_i <= 1'h0;
      op(8'h02, 8'h00, 8'h00);
      op(8'h03, 8'h00, 8'h14);
      op(8'h05, 8'h00, 8'h00);
      repeat (3) begin
         d = 8'($random(seed));
         op(8'h82, d, d & 8'h65);
         d = d & 8'h77;
         op(8'h83, d, {^d[6:0], d[6:0]});
      end
      $display("test 1 done");
      op(8'h82, 8'h45, 8'h45);
      step(4'h3, 5'h00);
      op(8'h82, 8'h00, 8'h44);
      step(4'h3, 5'h10);
      chk("rst", 8'h00, {7'h00, rst_out_low_o});
      op(8'h02, 8'h00, 8'h44);
      op(8'h03, 8'h00, 8'h14);
      step(4'h0, 5'h00);
      op(8'h82, 8'h01, 8'h01);
      step(4'h0, 5'h10);
      chk("rst", 8'h01, {7'h00, rst_out_low_o});
      op(8'h02, 8'h00, 8'h00);
      $display("test 2 done");
      step(4'h4, 5'h00);
      op(8'h82, 8'h21, 8'h21);
      step(4'h4, 5'h00);
      chk("fail", 8'h01, {7'h00, fail_output_o});
      step(4'hc, 5'h00);
      op(8'h82, 8'h05, 8'h05);
      step(4'hc, 5'h00);
      chk("fail", 8'h01, {7'h00, fail_output_o});
      op(8'h82, 8'h25, 8'h25);
      op(8'h83, 8'h73, 8'hf3);
      step(4'h4, 5'h08);
      chk("fail", 8'h00, {7'h00, fail_output_o});
      op(8'h02, 8'h00, 8'h05);
      @(negedge clk_i);
      chk("hw pins", 8'h03, {6'h00, charge_pump_enable_o, wd_fail_count_select_o});
      op(8'h03, 8'h00, 8'hb4);
      step(4'h4, 5'h05);
      op(8'h03, 8'h00, {5'h1e, hw_period_i});
      step(4'h4, 5'h02);
      op(8'h03, 8'h00, {5'h16, hw_period_i});
      @(negedge clk_i);
      chk("wd pins", {5'h03, hw_period_i}, {2'h0, wd_stop_disable_lo_o, wd_window_select_o,
         wd_start_on_bus_wake_o, wd_period_select_o});
      $display("test 3 done");
      repeat (2) @(negedge clk_i);
      results();
   end
endmodule : tb_top
